// ===== bench/rtci_host.sv
/* Host processor model: Avalon-MM master with read and write tasks.
   Assumes tasks are called right after a rising mclk edge. */
`timescale 1ns/10ps
`default_nettype none
module rtci_host (
    // Clock and answer
    input wire logic mclk,
    input wire logic waitrequest,
    input wire logic [31:0] readdata,
    // Request
    output logic [2:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata
);
    // Idle bus from time zero
    initial begin
        address = 3'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
    end
    // Released lines show inverted values so stale data never matches
    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        write <= 1'b0;
        address <= ~a;
        writedata <= ~d;
        @(posedge mclk);
    endtask
    // Prompt read, taken at the answer edge
    task automatic rd(input logic [2:0] a, output logic [7:0] q);
        address <= a;
        read <= 1'b1;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read <= 1'b0;
        address <= ~a;
        @(posedge mclk);
    endtask
endmodule // rtci_host
`default_nettype wire

// ===== bench/rtci_top_asserts.sv
/* Port checker for rtci_top: bus handshake, flags, pins.
   Assumes it is bound into rtci_top and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module rtci_top_asserts
    import rtci_pkg::*;
#(
    parameter int TICK_HZ = 32768,
    parameter int GUARD_US = 244
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Bus
    input wire logic [2:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Pins
    input wire logic irq_n,
    input wire logic square_wave_out
);
    // ----------------------------------------
    // Shadow registers
    // ----------------------------------------
    logic [7:0] ctrl_r, ctrl_nxt, rate_r, rate_nxt;
    logic ack_rd;
    assign ack_rd = read && !waitrequest;
    // Writes land at the edge that sees waitrequest low
    always_comb begin
        ctrl_nxt = ctrl_r;
        rate_nxt = rate_r;
        if (write && !waitrequest && address == 3'h1) begin
            ctrl_nxt = writedata[7:0] & (writedata[7] ? 8'hEF : 8'hFF);
        end
        if (write && !waitrequest && address == 3'h0) begin
            rate_nxt = {1'b0, writedata[6:0]};
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= 8'h00;
            rate_r <= 8'h00;
        end else begin
            ctrl_r <= ctrl_nxt;
            rate_r <= rate_nxt;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    chk_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("no answer one cycle after request");
    chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low longer than one cycle");
    chk_summary_mirror: assert property (ack_rd && address == 3'h2 |-> readdata[7] == !$past(irq_n))
        else $error("summary flag differs from interrupt pin");
    chk_read_clear: assert property (ack_rd && address == 3'h2 && !ctrl_r[6] |=> ##1 irq_n)
        else $error("interrupt still low after flag read");
    chk_sqw_idle: assert property ((!ctrl_r[3] || rate_r[3:0] == 4'h0 || rate_r[6:4] != 3'h2) [*3]
        |-> !square_wave_out)
        else $error("square wave active while disabled");
    chk_ctrl_echo: assert property (ack_rd && address == 3'h1 |-> readdata[7:3] == ctrl_r[7:3])
        else $error("control readback wrong");
    chk_rate_echo: assert property (ack_rd && address == 3'h0 |-> readdata[6:0] == rate_r[6:0])
        else $error("rate readback wrong");
    chk_irq_cause: assert property ((ctrl_r[6:4] == 3'h0) [*3] |-> irq_n)
        else $error("interrupt low with all sources masked");
    // Main scenarios reached
    cover property (ack_rd && address == 3'h2 && readdata[7]);
    cover property ($fell(irq_n));
    cover property ($rose(square_wave_out));
endmodule // rtci_top_asserts
bind rtci_top rtci_top_asserts #(.TICK_HZ(TICK_HZ), .GUARD_US(GUARD_US)) rtci_top_asserts_inst (
    .mclk(mclk), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .irq_n(irq_n), .square_wave_out(square_wave_out));
`default_nettype wire

// ===== bench/rtci_top_tb.sv
/* Self-checking bench for rtci_top with a host model.
   Assumes a one-cycle tick (TICK_HZ at mclk rate) and short guard. */
`timescale 1ns/10ps
`default_nettype none
module rtci_top_tb
    import rtci_pkg::*;
;
    localparam int TICK = 50000000;
    logic mclk, reset_n, read, write, waitrequest, irq_n, square_wave_out;
    logic [2:0] address;
    logic [31:0] writedata, readdata;
    logic [7:0] d, acc;
    int err_count, n_tests, seed, p, n;
    rtci_top #(.TICK_HZ(TICK), .GUARD_US(1)) rtci_top_inst (.mclk(mclk), .reset_n(reset_n),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .irq_n(irq_n),
        .square_wave_out(square_wave_out));
    rtci_host rtci_host_inst (.mclk(mclk), .waitrequest(waitrequest), .readdata(readdata),
        .address(address), .read(read), .write(write), .writedata(writedata));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results;
        $display("compares %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Upper data bits are ignored by the block, so they carry noise
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        logic [31:0] r;
        r = $random(seed);
        rtci_host_inst.wr(a, {r[31:8], v});
    endtask
    // Period in cycles of rate code c, per the tap table
    function automatic int exp_period(input int c);
        return ((c < 3) ? (1 << (c + 6)) : (1 << (c - 1))) * (50000000 / TICK);
    endfunction
    // Rise-to-rise cycles on the square wave
    task automatic meas(output int q);
        @(posedge mclk iff square_wave_out === 1'b0);
        @(posedge mclk iff square_wave_out === 1'b1);
        q = 0;
        do begin @(posedge mclk); q++; end while (square_wave_out !== 1'b0);
        do begin @(posedge mclk); q++; end while (square_wave_out !== 1'b1);
    endtask
    initial begin
        repeat (100000) @(posedge mclk);
        err_count++;
        results();
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        seed = 32'hf25f0226;
        err_count = 0;
        n_tests = 0;
        reset_n = 1'b0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        rtci_host_inst.rd(3'h0, d);
        check("rate reset", d, 0);
        rtci_host_inst.rd(3'h1, d);
        check("ctrl reset", d, 0);
        repeat (20) @(posedge mclk);
        rtci_host_inst.rd(3'h2, d);
        check("flags stopped", d, 0);
        check("irq idle", irq_n, 1);
        $display("reset test done");
        wr(3'h1, 8'h08);
        for (int c = 1; c < 13; c++) begin
            wr(3'h0, 8'h20 | c[7:0]);
            meas(p);
            check("sqw period", p, exp_period(c));
        end
        $display("rate sweep done");
        for (int o = 0; o < 8; o++) begin
            if (o != 2) begin
                wr(3'h0, {1'b0, o[2:0], 4'h3});
                rtci_host_inst.rd(3'h2, d);
                repeat (20) @(posedge mclk);
                rtci_host_inst.rd(3'h2, d);
                check("flags osc off", d, 0);
                check("sqw osc off", square_wave_out, 0);
            end
        end
        $display("oscillator modes done");
        wr(3'h0, 8'h23);
        repeat (10) @(posedge mclk);
        check("irq masked", irq_n, 1);
        rtci_host_inst.rd(3'h2, d);
        check("periodic polled", d[7:6], 2'b01);
        wr(3'h1, 8'h40);
        repeat (4) @(posedge mclk);
        check("irq periodic", irq_n, 0);
        check("sqw disabled", square_wave_out, 0);
        rtci_host_inst.rd(3'h3, d);
        check("sec on periodic", d, 0);
        rtci_host_inst.rd(3'h2, d);
        check("summary set", d[7:6], 2'b11);
        wr(3'h0, 8'h20);
        rtci_host_inst.rd(3'h2, d);
        repeat (4) @(posedge mclk);
        check("irq released", irq_n, 1);
        $display("periodic test done");
        wr(3'h1, 8'h90);
        rtci_host_inst.rd(3'h1, d);
        check("uie cleared by set", d[4], 0);
        wr(3'h3, 8'h05);
        wr(3'h6, 8'h06);
        wr(3'h7, 8'hC0);
        wr(3'h2, 8'hC0);
        rtci_host_inst.rd(3'h2, d);
        acc = 8'h00;
        do begin rtci_host_inst.rd(3'h2, d); acc = acc | d; end while (!d[4]);
        check("update with set", acc[5:4], 2'b11);
        rtci_host_inst.rd(3'h3, d);
        check("sec frozen", d, 8'h05);
        wr(3'h1, 8'h10);
        do rtci_host_inst.rd(3'h0, d); while (!d[7]);
        check("irq before transfer", irq_n, 1);
        n = 0;
        while (irq_n !== 1'b0) begin @(posedge mclk); n++; end
        check("guard bound", n <= 53, 1);
        rtci_host_inst.rd(3'h2, d);
        check("update flags", d, 8'h90);
        repeat (1000) @(posedge mclk);
        rtci_host_inst.rd(3'h2, d);
        check("no early update", d, 0);
        $display("update test done");
        results();
    end
endmodule // rtci_top_tb
`default_nettype wire

// ===== design/rtci_params.svh
/*
 * Constants for the clock interrupt, rate and update logic: register
 * offsets, field positions, reset values and timing counts.
 * Assumes a 50 MHz mclk and an Avalon-MM slave with word addresses.
 */
`ifndef RTCI_PARAMS_SVH
`define RTCI_PARAMS_SVH
// Register word addresses
`define RTCI_ADDR_RATE 3'h0
`define RTCI_ADDR_CTRL 3'h1
`define RTCI_ADDR_FLAG 3'h2
`define RTCI_ADDR_SEC 3'h3
`define RTCI_ADDR_MIN 3'h4
`define RTCI_ADDR_HOUR 3'h5
`define RTCI_ADDR_ASEC 3'h6
`define RTCI_ADDR_AMIN 3'h7
// Reset values
`define RTCI_RATE_RST 8'h00
`define RTCI_CTRL_RST 8'h00
// Field positions and codes
`define RTCI_FLAG_ANY 7
`define RTCI_OSC_RUN 3'h2
`define RTCI_DONT_CARE 2'h3
// Timing: 32.768 kHz divider base, guard of 244 us
`define RTCI_TICK_HZ 32768
`define RTCI_GUARD_US 244
`define RTCI_CLK_HZ 50000000
`endif

// ===== design/rtci_pkg.sv
/*
 * Types shared by the clock interrupt logic.
 * Assumes rtci_params.svh supplies the numbers.
 */
package rtci_pkg;
    typedef struct packed {
        logic any_interrupt_flag;
        logic periodic_flag;
        logic alarm_flag;
        logic update_end_flag;
    } rtci_flags_t;
    typedef enum logic [2:0] {
        RTCI_IDLE = 3'b001,
        RTCI_GUARD = 3'b010,
        RTCI_XFER = 3'b100
    } rtci_upd_t;
endpackage

// ===== design/rtci_top.sv
/*
 * Periodic/alarm/update interrupt logic, rate mux and update cycle.
 * Assumes an Avalon-MM master on mclk; time counts binary 24 h.
 */
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "rtci_params.svh"
module rtci_top
    import rtci_pkg::*;
#(
    parameter int TICK_HZ = `RTCI_TICK_HZ,
    parameter int GUARD_US = `RTCI_GUARD_US
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [2:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Pins
    output logic irq_n,
    output logic square_wave_out
);
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int TICK_DIV = `RTCI_CLK_HZ / TICK_HZ;
    // Guard never below one cycle so the sequencer always passes through it
    localparam int GUARD_CYC = (GUARD_US * (`RTCI_CLK_HZ / 1000000) > 0) ?
        GUARD_US * (`RTCI_CLK_HZ / 1000000) : 1;

    // Tap bit index for a rate code, 0 when none
    function automatic logic [3:0] tap_of(input logic [3:0] rs);
        case (rs)
            // Codes 1 and 2 repeat the periods of codes 8 and 9
            4'h1: tap_of = 4'h6;
            4'h2: tap_of = 4'h7;
            4'h0: tap_of = 4'h0;
            default: tap_of = 4'(rs - 4'h2);
        endcase
    endfunction

    // Binary wrap increment
    function automatic logic [7:0] inc_wrap(input logic [7:0] v, input logic [7:0] lim);
        inc_wrap = (v >= lim) ? 8'h00 : 8'(v + 8'h01);
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] rate_r, rate_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    rtci_flags_t flags_r, flags_nxt;
    logic [7:0] sec_r, sec_nxt, min_r, min_nxt, hour_r, hour_nxt;
    logic [7:0] usec_r, usec_nxt, umin_r, umin_nxt, uhour_r, uhour_nxt;
    logic [7:0] asec_r, asec_nxt, amin_r, amin_nxt, ahour_r, ahour_nxt;
    logic [15:0] pre_r, pre_nxt;
    logic [14:0] div_r, div_nxt;
    logic [31:0] guard_r, guard_nxt;
    rtci_upd_t upd_r, upd_nxt;
    logic tap_q_r, tap_q_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wait_r, wait_nxt;
    logic irq_n_r, irq_n_nxt;
    logic sqw_r, sqw_nxt;

    // Decoded strobes and levels; sec_edge, tap_edge and rd_flag are one cycle wide, tick too unless TICK_DIV is 1
    logic chain_run, tick, sec_edge, tap_now, tap_edge, rd_flag, alarm_hit;
    logic [3:0] tap;
    logic [7:0] ahour_eff;
    rtci_flags_t seen_flags;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // Oscillator field: only 010 runs the chain; every other value clears it
    always_comb begin
        chain_run = (rate_r[6:4] == `RTCI_OSC_RUN);
        tick = chain_run && (pre_r == 16'(TICK_DIV - 1));
        sec_edge = tick && (div_r == 15'h7FFF);
        tap = tap_of(rate_r[3:0]);
        tap_now = (tap != 4'h0) && div_r[tap];
        tap_edge = chain_run && tap_now && !tap_q_r;
        rd_flag = read && !wait_r && (address == `RTCI_ADDR_FLAG);
        // Flags as the pending read answer reported them
        seen_flags = rtci_flags_t'(rdata_r[`RTCI_FLAG_ANY -: 4]);
        ahour_eff = ahour_r;
        // Alarm judged on the time the transfer is about to post, so it
        // fires in the second whose time bytes equal the alarm bytes
        alarm_hit = ((asec_r[7:6] == `RTCI_DONT_CARE) || (asec_r == sec_nxt)) &&
            ((amin_r[7:6] == `RTCI_DONT_CARE) || (amin_r == min_nxt)) &&
            ((ahour_eff[7:6] == `RTCI_DONT_CARE) || (ahour_eff == hour_nxt));
    end

    // ----------------------------------------
    // Divider and update cycle
    // ----------------------------------------
    // Divider chain and update-cycle sequencer
    always_comb begin
        pre_nxt = pre_r;
        div_nxt = div_r;
        tap_q_nxt = chain_run && tap_now;
        guard_nxt = guard_r;
        upd_nxt = upd_r;
        sec_nxt = sec_r;
        min_nxt = min_r;
        hour_nxt = hour_r;
        usec_nxt = usec_r;
        umin_nxt = umin_r;
        uhour_nxt = uhour_r;
        if (!chain_run) begin
            pre_nxt = 16'h0000;
            div_nxt = 15'h0000;
        end else if (tick) begin
            pre_nxt = 16'h0000;
            div_nxt = 15'(div_r + 15'h0001);
        end else begin
            pre_nxt = 16'(pre_r + 16'h0001);
        end
        case (upd_r)
            RTCI_IDLE: begin
                if (sec_edge) begin
                    upd_nxt = RTCI_GUARD;
                    guard_nxt = 32'(GUARD_CYC - 1);
                end
            end
            RTCI_GUARD: begin
                if (guard_r == 32'h0) begin
                    upd_nxt = RTCI_XFER;
                end else begin
                    guard_nxt = 32'(guard_r - 32'h1);
                end
            end
            RTCI_XFER: begin
                upd_nxt = RTCI_IDLE;
                sec_nxt = inc_wrap(sec_r, 8'h3B);
                if (sec_r == 8'h3B) begin
                    min_nxt = inc_wrap(min_r, 8'h3B);
                    if (min_r == 8'h3B) begin
                        hour_nxt = inc_wrap(hour_r, 8'h17);
                    end
                end
            end
            default: upd_nxt = RTCI_IDLE;
        endcase
        // User copy follows internal one unless frozen by set bit
        if (!ctrl_r[7]) begin
            usec_nxt = sec_r;
            umin_nxt = min_r;
            uhour_nxt = hour_r;
        end
        // Host writes while frozen land in both copies
        if (write && !wait_r && ctrl_r[7]) begin
            case (address)
                `RTCI_ADDR_SEC: begin
                    sec_nxt = writedata[7:0];
                    usec_nxt = writedata[7:0];
                end
                `RTCI_ADDR_MIN: begin
                    min_nxt = writedata[7:0];
                    umin_nxt = writedata[7:0];
                end
                `RTCI_ADDR_HOUR: begin
                    hour_nxt = writedata[7:0];
                    uhour_nxt = writedata[7:0];
                end
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Bus, flags and pins
    // ----------------------------------------
    // Registers, flags and bus answers
    always_comb begin
        rate_nxt = rate_r;
        ctrl_nxt = ctrl_r;
        asec_nxt = asec_r;
        amin_nxt = amin_r;
        ahour_nxt = ahour_r;
        flags_nxt = flags_r;
        rdata_nxt = rdata_r;
        wait_nxt = 1'b1;
        // One wait cycle, answer on second edge
        if ((read || write) && wait_r) begin
            wait_nxt = 1'b0;
        end
        // Clear only what the answer reported; a flag set during the read survives
        if (rd_flag) begin
            flags_nxt.periodic_flag = flags_r.periodic_flag && !seen_flags.periodic_flag;
            flags_nxt.alarm_flag = flags_r.alarm_flag && !seen_flags.alarm_flag;
            flags_nxt.update_end_flag = flags_r.update_end_flag && !seen_flags.update_end_flag;
        end
        // Events set after the clear so a same-cycle event is kept
        if (tap_edge) flags_nxt.periodic_flag = 1'b1;
        if (upd_r == RTCI_XFER) begin
            flags_nxt.update_end_flag = 1'b1;
            if (alarm_hit) flags_nxt.alarm_flag = 1'b1;
        end
        if ((read || write) && wait_r) begin
            case (address)
                `RTCI_ADDR_RATE: rdata_nxt = {24'h0, (upd_r != RTCI_IDLE), rate_r[6:0]};
                `RTCI_ADDR_CTRL: rdata_nxt = {24'h0, ctrl_r};
                `RTCI_ADDR_FLAG: rdata_nxt = {24'h0, flags_r, 4'h0};
                `RTCI_ADDR_SEC: rdata_nxt = {24'h0, usec_r};
                `RTCI_ADDR_MIN: rdata_nxt = {24'h0, umin_r};
                `RTCI_ADDR_HOUR: rdata_nxt = {24'h0, uhour_r};
                `RTCI_ADDR_ASEC: rdata_nxt = {24'h0, asec_r};
                default: rdata_nxt = {24'h0, amin_r};
            endcase
        end
        if (write && !wait_r) begin
            case (address)
                `RTCI_ADDR_RATE: rate_nxt = {1'b0, writedata[6:0]};
                `RTCI_ADDR_CTRL: begin
                    ctrl_nxt = writedata[7:0];
                    if (writedata[7]) ctrl_nxt[4] = 1'b0;
                end
                `RTCI_ADDR_ASEC: asec_nxt = writedata[7:0];
                `RTCI_ADDR_AMIN: amin_nxt = writedata[7:0];
                `RTCI_ADDR_FLAG: ahour_nxt = writedata[7:0];
                default: ;
            endcase
        end
        // Summary follows enabled pairs; enables gate only their source
        flags_nxt.any_interrupt_flag =
            (flags_nxt.periodic_flag && ctrl_nxt[6]) ||
            (flags_nxt.alarm_flag && ctrl_nxt[5]) ||
            (flags_nxt.update_end_flag && ctrl_nxt[4]);
        irq_n_nxt = !flags_nxt.any_interrupt_flag;
        // Pin low unless enabled and a rate chosen and running
        sqw_nxt = ctrl_r[3] && tap_now && chain_run;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    // Reset loads constants only; next values come from the blocks above
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rate_r <= `RTCI_RATE_RST;
            ctrl_r <= `RTCI_CTRL_RST;
            flags_r <= '0;
            sec_r <= 8'h00;
            min_r <= 8'h00;
            hour_r <= 8'h00;
            usec_r <= 8'h00;
            umin_r <= 8'h00;
            uhour_r <= 8'h00;
            asec_r <= 8'h00;
            amin_r <= 8'h00;
            ahour_r <= 8'h00;
            pre_r <= 16'h0000;
            div_r <= 15'h0000;
            guard_r <= 32'h0;
            upd_r <= RTCI_IDLE;
            tap_q_r <= 1'b0;
            rdata_r <= 32'h0;
            wait_r <= 1'b1;
            irq_n_r <= 1'b1;
            sqw_r <= 1'b0;
        end else begin
            rate_r <= rate_nxt;
            ctrl_r <= ctrl_nxt;
            flags_r <= flags_nxt;
            sec_r <= sec_nxt;
            min_r <= min_nxt;
            hour_r <= hour_nxt;
            usec_r <= usec_nxt;
            umin_r <= umin_nxt;
            uhour_r <= uhour_nxt;
            asec_r <= asec_nxt;
            amin_r <= amin_nxt;
            ahour_r <= ahour_nxt;
            pre_r <= pre_nxt;
            div_r <= div_nxt;
            guard_r <= guard_nxt;
            upd_r <= upd_nxt;
            tap_q_r <= tap_q_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
            irq_n_r <= irq_n_nxt;
            sqw_r <= sqw_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Each pin is a register copy, so no decode glitch reaches it
    assign readdata = rdata_r;
    assign waitrequest = wait_r;
    assign irq_n = irq_n_r;
    assign square_wave_out = sqw_r;
endmodule // rtci_top
`default_nettype wire
